// file: sysclk_ctrl.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "sysclk_regs.svh"

// Function
// [R1] Select codes 000-110 use fast clock path; 111 uses sub clock.
// [R2] Fast clock comes from external crystal or internal RC per fast select.
// [R3] Sub clock comes from slow crystal or slow RC per slow select.
// [R4] Fast mode divides fast clock by power of two, 1 to 64.
// [R5] On move to sub clock, fast oscillator stops unless its enable holds.
// [R6] Six modes: fast, slow, sleep, three idle variants.
// [R7] Fast mode: CPU on, fast, sub and slow RC clocks running.
// [R8] Slow mode: CPU runs from sub clock chosen by slow select.
// [R9] Halt with both keep bits low: sleep, slow RC only if watchdog.
// [R10] Halt, keep fast low, keep slow high: idle_slow_only_mode, fast clock stops.
// [R11] Halt with both keep bits high: idle_both_mode, both oscillators run.
// [R12] Halt, keep fast high, keep slow low: idle_fast_only_mode, sub clock stops.
// [R13] Four 8-bit control registers with the documented field layout.
// [R14] Idle_slow_only_mode keeps system clock only on sub code; idle_fast_only_mode only on fast codes.
// [R15] Codes 000-110 divide by 1,2,4,...,64; 111 selects sub clock.
// [R16] Fast select 0 picks internal RC, 1 picks external crystal.
// [R17] Slow crystal usable only after start-up delay following enable.
module sysclk_ctrl
   import sysclk_pkg::*;
#(
   parameter int START_CYC = `OSC_START_CYC
)
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Oscillator ticks and system inputs
   input  wire logic        EXT_FAST_CRYSTAL,
   input  wire logic        INT_FAST_RC,
   input  wire logic        EXT_SLOW_CRYSTAL,
   input  wire logic        INT_SLOW_RC,
   input  wire logic        WDT_EN,
   input  wire logic        WAKE,
   // Clock and status outputs
   output logic             FAST_CLOCK,
   output logic             SUB_CLOCK,
   output logic             SLOW_RC_CLOCK,
   output logic             SYS_CLOCK,
   output logic             CPU_RUN,
   output logic [2:0]       MODE
);

   // ==========================================================
   // Decode helpers
   function automatic logic is_sub(input logic [2:0] sel);
      return sel == `SEL_SUB_CODE;
   endfunction

   // Low bits of the tick counter that must all be set for one divided tick
   function automatic logic [5:0] div_mask(input logic [2:0] sel);
      return 6'((7'h01 << sel) - 7'h01);
   endfunction

   // ==========================================================
   // Register state
   logic [7:0] sysclk_q,  sysclk_d;
   logic [7:0] rcctl_q,   rcctl_d;
   logic [7:0] xfctl_q,   xfctl_d;
   logic [7:0] xsctl_q,   xsctl_d;
   logic [31:0] prdata_q, prdata_d;
   logic        slverr_d;
   op_mode_t    mode_q,   mode_d;

   logic [2:0] sel;
   logic       fast_src, slow_src, keep_fast, keep_slow;
   logic       rc_stable, xf_stable, xs_stable;
   logic       wr, rd, rd_setup, halt_wr;

   assign sel       = sysclk_q[`SEL_MSB:`SEL_LSB];
   assign fast_src  = sysclk_q[`FAST_SRC_BIT];
   assign slow_src  = sysclk_q[`SLOW_SRC_BIT];
   assign keep_fast = sysclk_q[`KEEP_FAST_BIT];
   assign keep_slow = sysclk_q[`KEEP_SLOW_BIT];

   assign wr      = PSEL && PENABLE && PWRITE;
   assign rd      = PSEL && PENABLE && !PWRITE;
   assign rd_setup = PSEL && !PENABLE && !PWRITE;
   assign halt_wr = wr && PADDR == `CPU_HALT_ADDR && PWDATA[0];

   // ==========================================================
   // Oscillator start-up timers
   osc_startup #(.START_CYC(START_CYC)) u_rc_start
   (
      .clk    (CLK),
      .rst_n  (RST_N),
      .enable (rcctl_q[`ENABLE_BIT]),
      .stable (rc_stable)
   );

   osc_startup #(.START_CYC(START_CYC)) u_xf_start
   (
      .clk    (CLK),
      .rst_n  (RST_N),
      .enable (xfctl_q[`ENABLE_BIT]),
      .stable (xf_stable)
   );

   osc_startup #(.START_CYC(START_CYC)) u_xs_start   // see [R17]
   (
      .clk    (CLK),
      .rst_n  (RST_N),
      .enable (xsctl_q[`ENABLE_BIT]),
      .stable (xs_stable)
   );

   // ==========================================================
   // APB register file
   always_comb
   begin
      sysclk_d = sysclk_q;
      rcctl_d  = rcctl_q;
      xfctl_d  = xfctl_q;
      xsctl_d  = xsctl_q;
      prdata_d = prdata_q;
      slverr_d = 1'b0;
      if (wr)
      begin
         if (PADDR == `SYSCLK_CTRL_ADDR)
            sysclk_d = PWDATA[7:0] & 8'hef;   // see [R13]
         else if (PADDR == `FAST_RC_CTRL_ADDR)
            rcctl_d = PWDATA[7:0] & 8'h0d;
         else if (PADDR == `FAST_XTAL_CTRL_ADDR)
            xfctl_d = PWDATA[7:0] & 8'h05;
         else if (PADDR == `SLOW_XTAL_CTRL_ADDR)
            xsctl_d = PWDATA[7:0] & 8'h01;
         else if (PADDR != `CPU_HALT_ADDR)
            slverr_d = 1'b1;
      end
      // Read data is captured in the setup cycle so it stands at the access edge
      if (rd_setup)
      begin
         if (PADDR == `SYSCLK_CTRL_ADDR)
            prdata_d = {24'h000000, sysclk_q};
         else if (PADDR == `FAST_RC_CTRL_ADDR)
            prdata_d = {24'h000000, rcctl_q[7:2], rc_stable, rcctl_q[0]};
         else if (PADDR == `FAST_XTAL_CTRL_ADDR)
            prdata_d = {24'h000000, xfctl_q[7:2], xf_stable, xfctl_q[0]};
         else if (PADDR == `SLOW_XTAL_CTRL_ADDR)
            prdata_d = {24'h000000, xsctl_q[7:2], xs_stable, xsctl_q[0]};
         else if (PADDR == `MODE_STATUS_ADDR)
            prdata_d = {29'h00000000, mode_q};
         else
            prdata_d = 32'h00000000;
      end
      if (rd)
      begin
         if (PADDR != `SYSCLK_CTRL_ADDR && PADDR != `FAST_RC_CTRL_ADDR
            && PADDR != `FAST_XTAL_CTRL_ADDR && PADDR != `SLOW_XTAL_CTRL_ADDR
            && PADDR != `MODE_STATUS_ADDR && PADDR != `CPU_HALT_ADDR)
            slverr_d = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sysclk_q <= `SYSCLK_CTRL_RST;
         rcctl_q  <= `FAST_RC_CTRL_RST;
         xfctl_q  <= `FAST_XTAL_CTRL_RST;
         xsctl_q  <= `SLOW_XTAL_CTRL_RST;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         sysclk_q <= sysclk_d;
         rcctl_q  <= rcctl_d;
         xfctl_q  <= xfctl_d;
         xsctl_q  <= xsctl_d;
         prdata_q <= prdata_d;
      end
   end

   assign PREADY  = 1'b1;
   assign PRDATA  = prdata_q;
   assign PSLVERR = PSEL && PENABLE && slverr_d;

   // ==========================================================
   // Operating mode machine
   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         MODE_FAST, MODE_SLOW:   // see [R6]
         begin
            if (halt_wr)
            begin
               case ({keep_fast, keep_slow})
                  2'b00:   mode_d = MODE_SLEEP;   // see [R9]
                  2'b01:   mode_d = MODE_IDLE_SLOW_ONLY_MODE;   // see [R10]
                  2'b11:   mode_d = MODE_IDLE_BOTH_MODE;   // see [R11]
                  default: mode_d = MODE_IDLE_FAST_ONLY_MODE;   // see [R12]
               endcase
            end
            else
               mode_d = is_sub(sel) ? MODE_SLOW : MODE_FAST;   // see [R1]
         end
         default:
         begin
            if (WAKE)
               mode_d = is_sub(sel) ? MODE_SLOW : MODE_FAST;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         mode_q <= MODE_FAST;
      else
         mode_q <= mode_d;
   end

   // ==========================================================
   // Fast clock source and divider
   logic       fast_raw;
   logic       fast_on;
   logic       sub_on;
   logic       sys_on;
   logic [5:0] div_q, div_d;
   logic       fast_div;

   assign fast_raw = fast_src ? EXT_FAST_CRYSTAL : INT_FAST_RC;   // see [R2] see [R16]

   always_comb
   begin
      div_d = div_q;
      if (fast_on && fast_raw)
         div_d = div_q + 6'h01;   // see [R4]
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         div_q <= 6'h00;
      else
         div_q <= div_d;
   end

   // Tick at every 2^sel fast ticks
   always_comb
   begin
      fast_div = fast_raw && ((div_q & div_mask(sel)) == div_mask(sel));   // see [R15]
   end

   // ==========================================================
   // Clock gating per mode
   always_comb
   begin
      fast_on = 1'b1;
      sub_on  = 1'b1;
      sys_on  = 1'b1;
      case (mode_q)
         MODE_FAST:  fast_on = 1'b1;   // see [R7]
         MODE_SLOW:  fast_on = rcctl_q[`ENABLE_BIT] || xfctl_q[`ENABLE_BIT];   // see [R5]
         MODE_SLEEP:
         begin
            fast_on = 1'b0;
            sub_on  = 1'b0;
            sys_on  = 1'b0;
         end
         MODE_IDLE_SLOW_ONLY_MODE:
         begin
            fast_on = 1'b0;
            sys_on  = is_sub(sel);   // see [R14]
         end
         MODE_IDLE_BOTH_MODE: fast_on = 1'b1;
         MODE_IDLE_FAST_ONLY_MODE:
         begin
            sub_on = 1'b0;
            sys_on = !is_sub(sel);   // see [R14]
         end
         default:    fast_on = 1'b1;
      endcase
   end

   logic sub_raw;
   assign sub_raw = slow_src ? (EXT_SLOW_CRYSTAL && xs_stable) : INT_SLOW_RC;   // see [R3] see [R8]

   logic fast_clk_q, sub_clk_q, rc_clk_q, sys_clk_q;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         fast_clk_q <= 1'b0;
         sub_clk_q  <= 1'b0;
         rc_clk_q   <= 1'b0;
         sys_clk_q  <= 1'b0;
      end
      else
      begin
         fast_clk_q <= fast_on && fast_raw;
         sub_clk_q  <= sub_on && sub_raw;
         rc_clk_q   <= (mode_q != MODE_SLEEP || WDT_EN) && INT_SLOW_RC;   // see [R9]
         sys_clk_q  <= sys_on && (is_sub(sel) ? sub_raw : fast_on && fast_div);
      end
   end

   assign FAST_CLOCK    = fast_clk_q;
   assign SUB_CLOCK     = sub_clk_q;
   assign SLOW_RC_CLOCK = rc_clk_q;
   assign SYS_CLOCK     = sys_clk_q;
   assign CPU_RUN       = mode_q == MODE_FAST || mode_q == MODE_SLOW;
   assign MODE          = mode_q;

   // ==========================================================
   // Checks
   halt_sleep_a: assert property (@(posedge CLK) disable iff (!RST_N)
      CPU_RUN && halt_wr && !keep_fast && !keep_slow |=> mode_q == MODE_SLEEP)   // see [R9]
      else $error("halt did not enter sleep");
   halt_idle_slow_only_mode_a: assert property (@(posedge CLK) disable iff (!RST_N)
      CPU_RUN && halt_wr && !keep_fast && keep_slow |=> mode_q == MODE_IDLE_SLOW_ONLY_MODE)   // see [R10]
      else $error("halt did not enter idle_slow_only_mode");
   halt_idle_both_mode_a: assert property (@(posedge CLK) disable iff (!RST_N)
      CPU_RUN && halt_wr && keep_fast && keep_slow |=> mode_q == MODE_IDLE_BOTH_MODE)   // see [R11]
      else $error("halt did not enter idle_both_mode");
   halt_idle_fast_only_mode_a: assert property (@(posedge CLK) disable iff (!RST_N)
      CPU_RUN && halt_wr && keep_fast && !keep_slow |=> mode_q == MODE_IDLE_FAST_ONLY_MODE)   // see [R12]
      else $error("halt did not enter idle_fast_only_mode");
   slow_sel_a: assert property (@(posedge CLK) disable iff (!RST_N)
      CPU_RUN && !halt_wr |=> CPU_RUN && (mode_q == MODE_SLOW) == is_sub($past(sel)))   // see [R1]
      else $error("run mode does not follow select");
   sleep_quiet_a: assert property (@(posedge CLK) disable iff (!RST_N)
      mode_q == MODE_SLEEP && !WDT_EN ##1 mode_q == MODE_SLEEP |-> !SLOW_RC_CLOCK && !SYS_CLOCK)   // see [R9]
      else $error("clock running in sleep");
   idle_slow_only_mode_fast_a: assert property (@(posedge CLK) disable iff (!RST_N)
      mode_q == MODE_IDLE_SLOW_ONLY_MODE |=> !FAST_CLOCK)   // see [R10]
      else $error("fast clock running in idle_slow_only_mode");
   idle_fast_only_mode_sub_a: assert property (@(posedge CLK) disable iff (!RST_N)
      mode_q == MODE_IDLE_FAST_ONLY_MODE |=> !SUB_CLOCK)   // see [R12]
      else $error("sub clock running in idle_fast_only_mode");
   fast_pass_a: assert property (@(posedge CLK) disable iff (!RST_N)
      mode_q == MODE_FAST && !fast_src && INT_FAST_RC |=> FAST_CLOCK)   // see [R7]
      else $error("fast clock blocked in fast mode");
   reserved_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !sysclk_q[4] && xsctl_q[7:1] == 7'h00)   // see [R13]
      else $error("reserved bit set");

endmodule

// file: sysclk_regs.svh
`ifndef SYSCLK_REGS_SVH
`define SYSCLK_REGS_SVH

// ==========================================================
// Register byte addresses
`define SYSCLK_CTRL_ADDR      12'h000
`define FAST_RC_CTRL_ADDR     12'h004
`define FAST_XTAL_CTRL_ADDR   12'h008
`define SLOW_XTAL_CTRL_ADDR   12'h00c
`define CPU_HALT_ADDR         12'h010
`define MODE_STATUS_ADDR      12'h014

// ==========================================================
// Field positions
`define SEL_MSB               7
`define SEL_LSB               5
`define FAST_SRC_BIT          3
`define SLOW_SRC_BIT          2
`define KEEP_FAST_BIT         1
`define KEEP_SLOW_BIT         0
`define FREQ_MSB              3
`define FREQ_LSB              2
`define STABLE_BIT            1
`define ENABLE_BIT            0
`define XTAL_RANGE_BIT        2

// ==========================================================
// Reset values
`define SYSCLK_CTRL_RST       8'h00
`define FAST_RC_CTRL_RST      8'h01
`define FAST_XTAL_CTRL_RST    8'h00
`define SLOW_XTAL_CTRL_RST    8'h00

// ==========================================================
// Field codes and timing
`define SEL_SUB_CODE          3'h7
`define CLK_PERIOD_NS         50
`define OSC_START_NS          1000
`define OSC_START_CYC         ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: sysclk_pkg.sv
package sysclk_pkg;

   typedef enum logic [2:0]
   {
      MODE_FAST  = 3'b000,
      MODE_SLOW  = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_IDLE_SLOW_ONLY_MODE = 3'b011,
      MODE_IDLE_BOTH_MODE = 3'b100,
      MODE_IDLE_FAST_ONLY_MODE = 3'b101
   } op_mode_t;

endpackage

// file: osc_startup.sv
`timescale 1ns/1ps
`include "sysclk_regs.svh"

// ==========================================================
// Start-up timer: stable flag rises a fixed count after enable
module osc_startup
   import sysclk_pkg::*;
#(
   parameter int START_CYC = `OSC_START_CYC
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Oscillator control
   input  wire logic enable,
   output logic      stable
);

   localparam int CW = $clog2(START_CYC + 1);

   // The stable flag must lag enable by at least two edges
   if (START_CYC < 2)
   begin : g_bad_start
      $error("START_CYC must be at least 2");
   end

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          stable_q;
   logic          stable_d;

   always_comb
   begin
      cnt_d    = cnt_q;
      stable_d = stable_q;
      if (!enable)
      begin
         cnt_d    = '0;
         stable_d = 1'b0;
      end
      else if (!stable_q)
      begin
         if (cnt_q == CW'(START_CYC - 1))
            stable_d = 1'b1;
         else
            cnt_d = cnt_q + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q    <= '0;
         stable_q <= 1'b0;
      end
      else
      begin
         cnt_q    <= cnt_d;
         stable_q <= stable_d;
      end
   end

   assign stable = stable_q;

   start_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(enable) |-> !stable [*1] ##1 (!stable || !enable))
      else $error("oscillator reported stable too early");

endmodule

// file: system_clock_and_power_modes_tb_top.sv
`timescale 1ns/1ps
`include "sysclk_regs.svh"

`define CHK(a, e) \
   begin \
      checks++; \
      if ((a) !== (e)) \
      begin \
         error_cnt++; \
         $display("ERROR t=%0t got %h exp %h", $time, a, e); \
      end \
   end

module system_clock_and_power_modes_tb_top import sysclk_pkg::*;;
   localparam int START = 3;
   logic        CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic        EXT_FAST_CRYSTAL, INT_FAST_RC, EXT_SLOW_CRYSTAL, INT_SLOW_RC;
   logic        WDT_EN, WAKE, FAST_CLOCK, SUB_CLOCK, SLOW_RC_CLOCK, SYS_CLOCK, CPU_RUN;
   logic [2:0]  MODE;
   logic [3:0]  osc_run, tick;
   int          error_cnt, checks;

   sysclk_ctrl #(.START_CYC(START)) dut
   (
      .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .EXT_FAST_CRYSTAL(EXT_FAST_CRYSTAL), .INT_FAST_RC(INT_FAST_RC),
      .EXT_SLOW_CRYSTAL(EXT_SLOW_CRYSTAL), .INT_SLOW_RC(INT_SLOW_RC),
      .WDT_EN(WDT_EN), .WAKE(WAKE), .FAST_CLOCK(FAST_CLOCK), .SUB_CLOCK(SUB_CLOCK),
      .SLOW_RC_CLOCK(SLOW_RC_CLOCK), .SYS_CLOCK(SYS_CLOCK), .CPU_RUN(CPU_RUN), .MODE(MODE)
   );

   initial
   begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   // ==========================================================
   // Oscillator ticks; a cleared osc_run bit freezes that source
   always @(posedge CLK)
   begin
      tick             <= tick + 4'h1;
      INT_FAST_RC      <= osc_run[0] & tick[0];
      EXT_FAST_CRYSTAL <= osc_run[1] & tick[1];
      INT_SLOW_RC      <= osc_run[2] & tick[2];
      EXT_SLOW_CRYSTAL <= osc_run[3] & tick[3];
   end

   // ==========================================================
   // Shared tasks
   task automatic stop_test;
      $display("Errors %0d, checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         error_cnt++;
         stop_test();
      end
      err = PSLVERR;
      rd = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask

   // Which of {fast, sub, slow RC, system} clocks toggle within a window
   task automatic act(input int cyc, input logic [3:0] e);
      logic [3:0] first, seen;
      repeat (4) @(posedge CLK);
      first = {FAST_CLOCK, SUB_CLOCK, SLOW_RC_CLOCK, SYS_CLOCK};
      seen = 4'h0;
      repeat (cyc)
      begin
         @(posedge CLK);
         seen = seen | (first ^ {FAST_CLOCK, SUB_CLOCK, SLOW_RC_CLOCK, SYS_CLOCK});
      end
      `CHK(seen, e)
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      `CHK(MODE, MODE_FAST)
      `CHK(CPU_RUN, 1'b1)
      apb(1'b0, `SYSCLK_CTRL_ADDR, 32'h0);
      `CHK(rd, {24'h0, `SYSCLK_CTRL_RST})
      apb(1'b0, `FAST_RC_CTRL_ADDR, 32'h0);
      `CHK(rd & 32'hfffffffd, {24'h0, `FAST_RC_CTRL_RST})
      apb(1'b0, `FAST_XTAL_CTRL_ADDR, 32'h0);
      `CHK(rd, {24'h0, `FAST_XTAL_CTRL_RST})
      apb(1'b0, `MODE_STATUS_ADDR, 32'h0);
      `CHK(rd, {29'h0, MODE_FAST})
      apb(1'b1, `SYSCLK_CTRL_ADDR, 32'hff);
      apb(1'b0, `SYSCLK_CTRL_ADDR, 32'h0);
      `CHK(rd, 32'hef)
      apb(1'b1, `SYSCLK_CTRL_ADDR, 32'h0);
      apb(1'b1, 12'h0f0, 32'hff);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h0f0, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, `SLOW_XTAL_CTRL_ADDR, 32'h1);
      repeat (START + 2) @(posedge CLK);
      apb(1'b0, `SLOW_XTAL_CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h3)
      apb(1'b1, `SLOW_XTAL_CTRL_ADDR, 32'h2);
      apb(1'b0, `SLOW_XTAL_CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h0)
   endtask

   task automatic t_fast;
      for (int c = 0; c < 7; c++)
      begin
         apb(1'b1, `SYSCLK_CTRL_ADDR, {24'h0, 3'(c), 5'h0});
         act(40 << c, 4'hf);
         `CHK(MODE, MODE_FAST)
      end
      apb(1'b1, `FAST_XTAL_CTRL_ADDR, 32'h1);
      repeat (START + 2) @(posedge CLK);
      apb(1'b1, `SYSCLK_CTRL_ADDR, 32'h08);
      osc_run <= 4'he;
      act(32, 4'hf);
      osc_run <= 4'hd;
      act(32, 4'h6);
      apb(1'b1, `SYSCLK_CTRL_ADDR, 32'h0);
      osc_run <= 4'he;
      act(32, 4'h6);
      osc_run <= 4'hf;
      apb(1'b1, `FAST_XTAL_CTRL_ADDR, 32'h0);
   endtask

   task automatic t_slow;
      apb(1'b1, `SYSCLK_CTRL_ADDR, 32'he0);
      act(32, 4'hf);
      `CHK({CPU_RUN, MODE}, {1'b1, MODE_SLOW})
      apb(1'b1, `FAST_RC_CTRL_ADDR, 32'h0);
      act(32, 4'h7);
      apb(1'b1, `FAST_RC_CTRL_ADDR, 32'h1);
      apb(1'b1, `SLOW_XTAL_CTRL_ADDR, 32'h1);
      repeat (START + 2) @(posedge CLK);
      apb(1'b1, `SYSCLK_CTRL_ADDR, 32'he4);
      osc_run <= 4'hb;
      act(32, 4'hd);
      osc_run <= 4'h7;
      act(32, 4'ha);
      osc_run <= 4'hf;
      apb(1'b1, `SYSCLK_CTRL_ADDR, 32'h0);
      apb(1'b1, `SLOW_XTAL_CTRL_ADDR, 32'h0);
   endtask

   task automatic t_halt(input logic s7, input logic [1:0] k, input logic w);
      logic [2:0] m;
      logic [3:0] e;
      m = (k == 2'h0) ? MODE_SLEEP : (k == 2'h1) ? MODE_IDLE_SLOW_ONLY_MODE :
          (k == 2'h3) ? MODE_IDLE_BOTH_MODE : MODE_IDLE_FAST_ONLY_MODE;
      e = (k == 2'h0) ? {2'h0, w, 1'b0} : (k == 2'h1) ? {3'h3, s7} :
          (k == 2'h3) ? 4'hf : {3'h5, ~s7};
      WDT_EN <= w;
      apb(1'b1, `SYSCLK_CTRL_ADDR, {24'h0, {3{s7}}, 3'h0, k});
      apb(1'b1, `CPU_HALT_ADDR, 32'h1);
      act(32, e);
      `CHK({CPU_RUN, MODE}, {1'b0, m})
      WAKE <= 1'b1;
      @(posedge CLK);
      WAKE <= 1'b0;
      m = s7 ? MODE_SLOW : MODE_FAST;
      for (int n = 0; n < 10 && MODE !== m; n++)
         @(posedge CLK);
      `CHK({CPU_RUN, MODE}, {1'b1, m})
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      WDT_EN = 1'b1;
      WAKE = 1'b0;
      osc_run = 4'hf;
      tick = 4'h0;
      error_cnt = 0;
      checks = 0;
      RST_N = 1'b0;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      t_regs();
      t_fast();
      t_slow();
      for (int i = 0; i < 8; i++)
         t_halt(i[2], i[1:0], 1'b1);
      t_halt(1'b0, 2'h0, 1'b0);
      stop_test();
   end
endmodule
